// ==== verilog/pff_feedforward_limit.sv ====
/*
 Top of the interleaved PFC control logic: period timing, feed-forward level selection,
 multiplier reference and two phase channels.
 Assumes voltage and current codes are synchronous samples; comparator bits may be asynchronous.
*/
// How it works
// - Peak comparator trip turns phase gate off
// - Tripped gate stays off until next period
// - Seven thresholds select one of eight levels
// - Rising thresholds 1.0 to 2.6 volts
// - Reference is 17 times line times excess over factor
// - Falling thresholds sit five percent lower
// - Rise promptly, fall only after zero crossing
// - Zero crossing: below 0.7 V 50 us
// - On-time uses sensed current, off-time synthesized
// - Output below input gives zero down-slope
// - Duty resumes once input falls below output
// - Open output voltage sense reads low, stays safe
// - Phase B starts half a period after A
`timescale 1ns/100ps
`default_nettype none
module pff_feedforward_limit
    import pff_pkg::*;
#(
    parameter int PERIOD_CYCLES = 1250,
    parameter int ZC_CYCLES = PFF_ZC_CYCLES,
    parameter int SLOPE_SHIFT = 0
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [PFF_MV_W-1:0] lineVoltageSense,
    input wire logic [PFF_MV_W-1:0] outputVoltageSense,
    input wire logic [PFF_MV_W-1:0] errorAmpOutput,
    input wire logic [PFF_CUR_W-1:0] currentSensePhaseA,
    input wire logic [PFF_CUR_W-1:0] currentSensePhaseB,
    input wire logic peakLimitTripA,
    input wire logic peakLimitTripB,
    output logic gateOutPhaseA,
    output logic gateOutPhaseB,
    output logic [1:0] peakLimited,
    output logic [2:0] quantizedFeedforwardLevel,
    output logic [PFF_CUR_W-1:0] multiplierReferenceOut
);
    localparam int HALF = PERIOD_CYCLES / 2;

    if (PERIOD_CYCLES < 4 || PERIOD_CYCLES > 65535 || ZC_CYCLES < 2 || ZC_CYCLES > 65535
        || SLOPE_SHIFT < 0 || SLOPE_SHIFT > 7)
    begin : g_check
        $error("pff_feedforward_limit: unsupported parameter value");
    end

    logic [15:0] perCnt_q;
    logic [15:0] zcCnt_q;
    logic [PFF_MV_W-1:0] peak_q;
    logic [2:0] level_q;
    logic [PFF_CUR_W-1:0] slope_q;
    logic enable_q;
    logic [1:0] periodStart;
    logic lineLow;
    logic zcEvent;
    logic [PFF_THRESH-1:0] aboveRise;
    logic [PFF_THRESH-1:0] aboveFall;
    logic [2:0] riseLvl;
    logic [2:0] fallLvl;
    logic [PFF_MV_W-1:0] eaExcess;
    logic [28:0] product;
    logic [28:0] quotient;
    logic [PFF_CUR_W-1:0] slopeRaw;
    pff_phase_t status [2];
    logic [PFF_CUR_W-1:0] csCode [2];
    logic [1:0] tripRaw;

    // Period timing, phase B offset by half a period
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            perCnt_q <= '0;
        else if (perCnt_q == 16'(PERIOD_CYCLES - 1))
            perCnt_q <= '0;
        else
            perCnt_q <= perCnt_q + 16'h0001;
    end

    assign periodStart[0] = (perCnt_q == 16'h0000);
    assign periodStart[1] = (perCnt_q == 16'(HALF));

    // Zero-crossing filter
    assign lineLow = (lineVoltageSense < PFF_ZC_MV);
    assign zcEvent = lineLow && (zcCnt_q == 16'(ZC_CYCLES - 1));

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            zcCnt_q <= '0;
        else if (!lineLow)
            zcCnt_q <= '0;
        else if (zcCnt_q < 16'(ZC_CYCLES))
            zcCnt_q <= zcCnt_q + 16'h0001;
    end

    // Peak held over one half line cycle
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            peak_q <= '0;
        else if (zcEvent)
            peak_q <= lineVoltageSense;
        else if (lineVoltageSense > peak_q)
            peak_q <= lineVoltageSense;
    end

    for (genvar i = 0; i < PFF_THRESH; i++)
    begin : g_thresh
        localparam logic [PFF_MV_W-1:0] FALL_MV = PFF_MV_W'(PFF_RISE_MV[i] * PFF_HYST_PCT / 100);
        assign aboveRise[i] = (lineVoltageSense >= PFF_RISE_MV[i]);
        assign aboveFall[i] = (peak_q >= FALL_MV);
    end

    always_comb
    begin
        riseLvl = 3'h0;
        fallLvl = 3'h0;
        for (int k = 0; k < PFF_THRESH; k++)
        begin
            riseLvl = riseLvl + {2'h0, aboveRise[k]};
            fallLvl = fallLvl + {2'h0, aboveFall[k]};
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            level_q <= PFF_LEVEL_RESET;
        else if (riseLvl > level_q)
            level_q <= riseLvl;
        else if (zcEvent && fallLvl < level_q)
            level_q <= fallLvl;
    end

    // Multiplier reference
    assign eaExcess = (errorAmpOutput > PFF_EA_OFFSET_MV) ? errorAmpOutput - PFF_EA_OFFSET_MV : '0;
    assign product = 29'(PFF_MULT_GAIN) * 29'(lineVoltageSense) * 29'(eaExcess);
    assign quotient = product / {17'h0, PFF_KFF_MILLI[level_q]};

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            multiplierReferenceOut <= '0;
        else
            multiplierReferenceOut <= quotient[PFF_CUR_W-1:0];
    end

    // Synthesizer slope and open output-sense guard
    assign slopeRaw = (outputVoltageSense > lineVoltageSense)
        ? PFF_CUR_W'(outputVoltageSense - lineVoltageSense) << SLOPE_SHIFT : '0;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            slope_q <= '0;
            enable_q <= 1'b0;
        end
        else
        begin
            slope_q <= slopeRaw;
            enable_q <= (outputVoltageSense != '0);
        end
    end

    assign csCode[0] = currentSensePhaseA;
    assign csCode[1] = currentSensePhaseB;
    assign tripRaw = {peakLimitTripB, peakLimitTripA};

    for (genvar p = 0; p < 2; p++)
    begin : g_phase
        pff_phase u_phase (
            .clock(clock),
            .reset(reset),
            .periodStart(periodStart[p]),
            .enable(enable_q),
            .overLimitRaw(tripRaw[p]),
            .currentSense(csCode[p]),
            .reference(multiplierReferenceOut),
            .slope(slope_q),
            .status(status[p])
        );
        assign peakLimited[p] = status[p].limited;
    end

    assign gateOutPhaseA = status[0].gate;
    assign gateOutPhaseB = status[1].gate;
    assign quantizedFeedforwardLevel = level_q;

    sequence s_lowRun;
        lineLow [*8];
    endsequence

    a_level_up: assert property (@(posedge clock) disable iff (reset)
        riseLvl > level_q |=> level_q == $past(riseLvl))
        else $error("Level did not rise promptly");

    a_level_hold: assert property (@(posedge clock) disable iff (reset)
        !zcEvent |=> level_q >= $past(level_q))
        else $error("Level fell without a zero crossing");

    a_level_hyst: assert property (@(posedge clock) disable iff (reset)
        zcEvent && riseLvl <= level_q |=>
            level_q == (($past(fallLvl) < $past(level_q)) ? $past(fallLvl) : $past(level_q)))
        else $error("Level step-down ignored falling thresholds");

    a_zc_count: assert property (@(posedge clock) disable iff (reset)
        zcEvent |-> zcCnt_q == 16'(ZC_CYCLES - 1) && lineLow)
        else $error("Zero crossing taken too early");

    a_zc_dip: assert property (@(posedge clock) disable iff (reset)
        s_lowRun ##1 !lineLow |=> zcCnt_q == '0)
        else $error("Dip counter not cleared");

    a_ref_zero: assert property (@(posedge clock) disable iff (reset)
        errorAmpOutput <= PFF_EA_OFFSET_MV |=> multiplierReferenceOut == '0)
        else $error("Reference not zero at low error amp");

    a_slope_block: assert property (@(posedge clock) disable iff (reset)
        outputVoltageSense <= lineVoltageSense |=> slope_q == '0)
        else $error("Slope nonzero with output below input");

    a_phase_a_start: assert property (@(posedge clock) disable iff (reset)
        $rose(gateOutPhaseA) |-> perCnt_q == 16'h0001)
        else $error("Phase A started off its slot");

    a_phase_b_start: assert property (@(posedge clock) disable iff (reset)
        $rose(gateOutPhaseB) |-> perCnt_q == 16'(HALF + 1))
        else $error("Phase B not half a period after A");

    a_open_safe: assert property (@(posedge clock) disable iff (reset)
        outputVoltageSense == '0 ##1 outputVoltageSense == '0 |=> !$rose(gateOutPhaseA) && !$rose(gateOutPhaseB))
        else $error("Gate started with open output sense");

    a_reset_level: assert property (@(posedge clock)
        reset |=> level_q == PFF_LEVEL_RESET || !reset)
        else $error("Level not reset");
endmodule : pff_feedforward_limit
`default_nettype wire

// ==== verilog/pff_pkg.sv ====
/*
 Shared constants and types for the interleaved PFC feed-forward and peak-limit logic.
 Assumes voltages arrive as millivolt codes and currents as codes in the reference's units.
*/
package pff_pkg;
    localparam int PFF_MV_W = 12;
    localparam int PFF_CUR_W = 20;
    localparam int PFF_LEVELS = 8;
    localparam int PFF_THRESH = PFF_LEVELS - 1;
    // Rising thresholds, level 2 up to level 8
    localparam logic [PFF_THRESH-1:0][PFF_MV_W-1:0] PFF_RISE_MV = {
        12'ha28, 12'h8ca, 12'h79e, 12'h672, 12'h578, 12'h4b0, 12'h3e8};
    localparam int PFF_HYST_PCT = 32'h5f;
    // Factors scaled by one thousand, level 1 at index 0
    localparam logic [PFF_LEVELS-1:0][PFF_MV_W-1:0] PFF_KFF_MILLI = {
        12'hf11, 12'hb6a, 12'h897, 12'h644, 12'h484, 12'h347, 12'h258, 12'h18e};
    localparam logic [PFF_MV_W-1:0] PFF_ZC_MV = 12'h2bc;
    localparam logic [PFF_MV_W-1:0] PFF_EA_OFFSET_MV = 12'h3e8;
    localparam logic [4:0] PFF_MULT_GAIN = 5'h11;
    localparam int PFF_CLK_PERIOD_NS = 32'h8;
    localparam int PFF_ZC_TIME_NS = 32'hc350;
    localparam int PFF_ZC_CYCLES = (PFF_ZC_TIME_NS + PFF_CLK_PERIOD_NS - 1) / PFF_CLK_PERIOD_NS;
    localparam logic [2:0] PFF_LEVEL_RESET = 3'h0;

    typedef enum logic [1:0] {PH_OFF, PH_ON, PH_LIMIT} pff_phase_state_t;

    typedef struct packed {
        logic gate;
        logic limited;
    } pff_phase_t;
endpackage : pff_pkg

// ==== verilog/pff_phase.sv ====
/*
 One PWM phase: peak-limit latch, current synthesizer and gate flip-flop.
 Assumes periodStart pulses once per PWM period and slope is zero when output is below input.
*/
`timescale 1ns/100ps
`default_nettype none
module pff_phase
    import pff_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic periodStart,
    input wire logic enable,
    input wire logic overLimitRaw,
    input wire logic [PFF_CUR_W-1:0] currentSense,
    input wire logic [PFF_CUR_W-1:0] reference,
    input wire logic [PFF_CUR_W-1:0] slope,
    output pff_phase_t status
);
    logic overLimitS1_q;
    logic overLimit_q;
    pff_phase_state_t state_q;
    pff_phase_state_t state_d;
    logic [PFF_CUR_W-1:0] synth_q;

    // Comparator synchroniser
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            overLimitS1_q <= 1'b0;
            overLimit_q <= 1'b0;
        end
        else
        begin
            overLimitS1_q <= overLimitRaw;
            overLimit_q <= overLimitS1_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        if (periodStart)
        begin
            // Trip seen at a period start wins over the restart
            if (overLimit_q)
                state_d = PH_LIMIT;
            else if (enable && synth_q <= reference)
                state_d = PH_ON;
            else
                state_d = PH_OFF;
        end
        else
        begin
            unique case (state_q)
                PH_ON:
                begin
                    if (overLimit_q)
                        state_d = PH_LIMIT;
                    else if (currentSense > reference)
                        state_d = PH_OFF;
                end
                PH_LIMIT: state_d = PH_LIMIT;
                PH_OFF: state_d = PH_OFF;
                default: state_d = PH_OFF;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q <= PH_OFF;
            status <= '0;
        end
        else
        begin
            state_q <= state_d;
            status.gate <= (state_d == PH_ON);
            status.limited <= (state_d == PH_LIMIT);
        end
    end

    // Measured current while on, synthesized down-slope while off
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            synth_q <= '0;
        else if (state_q == PH_ON)
            synth_q <= currentSense;
        else if (synth_q > slope)
            synth_q <= synth_q - slope;
        else
            synth_q <= '0;
    end

    sequence s_limitSeen;
        overLimitRaw ##2 (state_q == PH_ON || periodStart);
    endsequence

    a_limit_gate_off: assert property (@(posedge clock) disable iff (reset)
        s_limitSeen |=> !status.gate && status.limited)
        else $error("Gate stayed on after peak limit");

    a_limit_hold: assert property (@(posedge clock) disable iff (reset)
        state_q == PH_LIMIT && !periodStart |=> state_q == PH_LIMIT && !status.gate)
        else $error("Limited phase re-enabled inside the period");

    a_synth_track: assert property (@(posedge clock) disable iff (reset)
        state_q == PH_ON |=> synth_q == $past(currentSense))
        else $error("Synthesizer did not follow sensed current");

    a_slope_zero: assert property (@(posedge clock) disable iff (reset)
        state_q != PH_ON && slope == '0 |=> synth_q == $past(synth_q))
        else $error("Synthesized current fell with zero slope");

    a_sync_delay: assert property (@(posedge clock) disable iff (reset)
        $rose(overLimitRaw) ##1 overLimitRaw |=> overLimit_q)
        else $error("Limit comparator not synchronised in two cycles");
endmodule : pff_phase
`default_nettype wire

// ==== test/pff_power_stage.sv ====
/*
 Behavioural boost stage for both phases: inductor current ramps while a gate is on.
 Assumes active-high gates and one shared clock; peak comparators are plain levels.
*/
`timescale 1ns/100ps
`default_nettype none
module pff_power_stage
    import pff_pkg::*;
#(
    parameter int STEP = 1000
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic gateA,
    input wire logic gateB,
    input wire logic [PFF_CUR_W-1:0] limitLevel,
    output logic [PFF_CUR_W-1:0] currentA,
    output logic [PFF_CUR_W-1:0] currentB,
    output logic tripA,
    output logic tripB
);
    logic [PFF_CUR_W-1:0] curA_q;
    logic [PFF_CUR_W-1:0] curB_q;

    // Current ramps while on, discharges at once when off
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            curA_q <= '0;
        else
            curA_q <= gateA ? curA_q + PFF_CUR_W'(STEP) : '0;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            curB_q <= '0;
        else
            curB_q <= gateB ? curB_q + PFF_CUR_W'(STEP) : '0;
    end

    assign currentA = curA_q;
    assign currentB = curB_q;
    // Comparators follow the sensed current without delay
    assign tripA = curA_q > limitLevel;
    assign tripB = curB_q > limitLevel;
endmodule : pff_power_stage
`default_nettype wire

// ==== test/pff_feedforward_limit_tb.sv ====
/*
 Self-checking bench for the feed-forward and peak-limit logic.
 Assumes the behavioural power stage model and shortened period and zero-crossing counts.
*/
`timescale 1ns/100ps
`default_nettype none
module pff_feedforward_limit_tb;
    import pff_pkg::*;
    localparam int PER = 40;
    localparam int ZC = 20;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [PFF_MV_W-1:0] lineV = 12'h320;
    logic [PFF_MV_W-1:0] outV = 12'hbb8;
    logic [PFF_MV_W-1:0] eaV = 12'h7d0;
    logic [PFF_CUR_W-1:0] limitCur = 20'h02710;
    logic [PFF_CUR_W-1:0] current_sense_phase_a;
    logic [PFF_CUR_W-1:0] current_sense_phase_b;
    logic tripA;
    logic tripB;
    logic gateA;
    logic gateB;
    logic [1:0] limited;
    logic [2:0] level;
    logic [PFF_CUR_W-1:0] refOut;
    int n_errors = 0;
    int comparisons = 0;
    int rise[7] = '{1000, 1200, 1400, 1650, 1950, 2250, 2600};
    int kff[8] = '{398, 600, 839, 1156, 1604, 2199, 2922, 3857};

    always #4 clock = ~clock;

    pff_feedforward_limit #(.PERIOD_CYCLES(PER), .ZC_CYCLES(ZC), .SLOPE_SHIFT(0)) u_pff_feedforward_limit (
        .clock(clock), .reset(reset), .lineVoltageSense(lineV), .outputVoltageSense(outV),
        .errorAmpOutput(eaV), .currentSensePhaseA(current_sense_phase_a), .currentSensePhaseB(current_sense_phase_b),
        .peakLimitTripA(tripA), .peakLimitTripB(tripB), .gateOutPhaseA(gateA), .gateOutPhaseB(gateB),
        .peakLimited(limited), .quantizedFeedforwardLevel(level), .multiplierReferenceOut(refOut));

    pff_power_stage u_pff_power_stage (
        .clock(clock), .reset(reset), .gateA(gateA), .gateB(gateB), .limitLevel(limitCur),
        .currentA(current_sense_phase_a), .currentB(current_sense_phase_b), .tripA(tripA), .tripB(tripB));

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask : check_eq

    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask : cycles

    task automatic wait_gate_a(input logic want, input int bound, input string what);
        int k;
        k = 0;
        while (gateA !== want && k < bound)
        begin
            @(negedge clock);
            k++;
        end
        check_eq(gateA, want, what);
        if (gateA !== want)
            complete_run();
    endtask : wait_gate_a

    task automatic count_on(input int n, output int hits);
        hits = 0;
        repeat (n)
        begin
            @(negedge clock);
            if (gateA !== 1'b0 || gateB !== 1'b0)
                hits++;
        end
    endtask : count_on

    task automatic apply_reset;
        reset = 1'b1;
        cycles(8);
        check_eq(level, 0, "level in reset");
        check_eq(limited, 0, "limit flags in reset");
        check_eq({gateA, gateB}, 0, "gates in reset");
        reset = 1'b0;
        cycles(3);
        check_eq(refOut, 17 * 800 * 1000 / kff[0], "reference at level one");
    endtask : apply_reset

    task automatic level_rise;
        for (int i = 0; i < 7; i++)
        begin
            lineV = 12'(rise[i] - 1);
            cycles(4);
            check_eq(level, i, "level just below threshold");
            lineV = 12'(rise[i]);
            cycles(4);
            check_eq(level, i + 1, "level at threshold");
            check_eq(refOut, 17 * rise[i] * 1000 / kff[i + 1], "scaled reference");
        end
    endtask : level_rise

    task automatic level_fall;
        lineV = 12'h258;
        cycles(ZC + 5);
        check_eq(level, 7, "level after high half cycle");
        lineV = 12'h47e;
        cycles(10);
        lineV = 12'h258;
        cycles(ZC - 5);
        lineV = 12'h47e;
        cycles(10);
        check_eq(level, 7, "level after short dip");
        lineV = 12'h258;
        cycles(ZC - 2);
        check_eq(level, 7, "level before crossing");
        cycles(5);
        check_eq(level, 2, "level after crossing");
        lineV = 12'h320;
    endtask : level_fall

    task automatic gate_interleave;
        int kB;
        int kTrip;
        int kOff;
        logic held;
        kB = -1;
        kTrip = -1;
        kOff = -1;
        held = 1'b1;
        wait_gate_a(1'b0, 2 * PER, "phase A idle");
        wait_gate_a(1'b1, 2 * PER, "phase A starts");
        for (int k = 1; k <= PER; k++)
        begin
            @(negedge clock);
            if (gateB === 1'b1 && kB < 0)
                kB = k;
            if (tripA === 1'b1 && kTrip < 0)
                kTrip = k;
            if (gateA === 1'b0 && kOff < 0)
                kOff = k;
            if (kOff > 0 && k < PER && (gateA !== 1'b0 || limited[0] !== 1'b1))
                held = 1'b0;
        end
        check_eq(gateA, 1'b1, "phase A restarts next period");
        check_eq(limited, 2, "limit flags at phase A restart");
        check_eq(held, 1'b1, "phase A held off after trip");
        check_eq(kOff - kTrip, 3, "trip to gate off delay");
        check_eq(kB, PER / 2, "phase B offset");
    endtask : gate_interleave

    task automatic zero_duty;
        int hits;
        eaV = 12'h41a;
        wait_gate_a(1'b0, PER, "current loop ends pulse");
        wait_gate_a(1'b1, 2 * PER, "switching at low reference");
        outV = 12'h2bc;
        cycles(PER);
        count_on(3 * PER, hits);
        check_eq(hits, 0, "no duty with output below input");
        outV = 12'hbb8;
        wait_gate_a(1'b1, 3 * PER, "duty resumes");
        outV = 12'h000;
        cycles(PER);
        count_on(3 * PER, hits);
        check_eq(hits, 0, "no duty with open output sense");
        outV = 12'hbb8;
    endtask : zero_duty

    initial
    begin
        apply_reset();
        level_rise();
        level_fall();
        @(negedge clock);
        apply_reset();
        gate_interleave();
        zero_duty();
        complete_run();
    end
endmodule : pff_feedforward_limit_tb
`default_nettype wire
